// ===== opsvi_pkg.sv
// Shared constants for the one-pin voltage set link and its controller
package opsvi_pkg;
  localparam logic [7:0] DEV_ADDR = 8'h4e;
  localparam int RFA_POS = 7;
  localparam int SEL_HI_POS = 6;
  localparam int SEL_LO_POS = 5;
  localparam int VAL_W = 5;
  localparam int BYTE_BITS = 8;
  localparam int FRAME_BITS = 16;
  localparam logic [1:0] SEL_C1_LOW = 2'h0;
  localparam logic [1:0] SEL_C1_HIGH = 2'h1;
  localparam logic [1:0] SEL_C2 = 2'h2;
  localparam logic [1:0] SEL_RSVD = 2'h3;
  localparam logic [4:0] C1_LOW_RST = 5'h00;
  localparam logic [4:0] C1_HIGH_RST = 5'h00;
  localparam logic [4:0] C2_RST = 5'h00;
  localparam int CLK_MHZ = 50;
  localparam int T_START_US = 170;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int T_ACK_MAX_US = 520;
  localparam int ACK_MAX_CYC = T_ACK_MAX_US * CLK_MHZ;
  localparam int T_TIMEOUT_US = 1000;
  localparam int TIMEOUT_CYC = T_TIMEOUT_US * CLK_MHZ;
  localparam int RESP_DELAY_CYC = 100;
  localparam int HOST_ACK_WAIT_CYC = 200;
  localparam int ACK_SAMPLE_CYC = 8;
  localparam int BIT_SHORT_CYC = 100;
  localparam int BIT_LONG_CYC = 300;
  localparam int START_HOLD_CYC = 200;
  localparam int EOS_CYC = 200;
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] EN_OFS = 8'h08;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_READY = 2;
  localparam int EN_C1 = 0;
  localparam int EN_C2 = 1;
endpackage

// ===== opsvi_if.sv
// Shared one-wire line between controller and device
`timescale 1ns/1ps
interface opsvi_if;
  logic host_o;
  logic host_oe_n;
  logic dev_o;
  logic dev_oe_n;
  logic line;
  // Wired-AND with pull-up: released line reads high
  assign line = ~((~host_oe_n & ~host_o) | (~dev_oe_n & ~dev_o));
  modport dev (input line, output dev_o, output dev_oe_n);
  modport host (input line, output host_o, output host_oe_n);
endinterface

// ===== opsvi_dev.sv
// Device end: line decoder, level registers, acknowledge and mode select
// Operation
// - First byte must equal fixed device address
// - Data MSB requests acknowledge after good frame
// - Two select bits, five value bits, three registers
// - Acknowledge pulls line low, only when requested
// - Host provides line pull-up
// - Push-pull master never requests acknowledge
// - Selector pin picks high or low register
// - Select 01 high register, 00 low register
// - Select 10 converter-2 register, 11 reserved
// - Analog variant lacks converter-1 high register
// - Interface active while either enable high
// - Start-up wait after activation before data
// - Bit value from high versus low time ratio
// - Host sends MSB first, start, end-of-stream
// - Acknowledge after delay, bounded time, good frame
// - High forces fixed frequency; long low releases
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module opsvi_dev
  import opsvi_pkg::*;
#(
  parameter bit DIGITAL_SEL = 1'b1,
  parameter int CNT_W = 16,
  parameter int START_CYCLES = START_CYC,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int ACK_CYCLES = ACK_MAX_CYC,
  parameter int DELAY_CYCLES = RESP_DELAY_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  opsvi_if.dev link, // Shared line
  input wire logic conv1_on, // Converter 1 enable pin
  input wire logic conv2_on, // Converter 2 enable pin
  input wire logic conv1_level_selector_pin, // Converter 1 register selector pin
  output logic [VAL_W-1:0] conv1_level, // Active converter 1 level
  output logic [VAL_W-1:0] conv2_level, // Converter 2 level
  output logic forced_pwm, // Fixed-frequency mode request
  output logic iface_ready // Ready for data reception
);
  typedef enum logic [8:0] {
    ST_OFF = 9'h001,
    ST_WAKE = 9'h002,
    ST_IDLE = 9'h004,
    ST_LOW = 9'h008,
    ST_HIGH = 9'h010,
    ST_GAP_LO = 9'h020,
    ST_GAP_HI = 9'h040,
    ST_ACKW = 9'h080,
    ST_ACK = 9'h100
  } opsvi_dst_t;

  localparam logic [CNT_W-1:0] WAKE_END = CNT_W'(START_CYCLES - 1);
  localparam logic [CNT_W-1:0] TO_LIM = CNT_W'(TIMEOUT_CYCLES);
  localparam logic [CNT_W-1:0] ACK_END = CNT_W'(ACK_CYCLES - 1);
  localparam logic [CNT_W-1:0] DLY_END = CNT_W'(DELAY_CYCLES - 1);

  if (CNT_W < 8 || START_CYCLES < 1 || ACK_CYCLES < 1 || DELAY_CYCLES < 1 ||
      TIMEOUT_CYCLES >= 2 ** CNT_W || START_CYCLES > 2 ** CNT_W || ACK_CYCLES > 2 ** CNT_W) begin : g_bad
    $error("opsvi_dev: counts do not fit the counter width");
  end

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] pins;
  logic line_s;
  logic active;
  logic sel_s;
  logic line_d_reg;
  logic fall;
  logic rise;

  assign pins = {conv1_level_selector_pin, conv2_on, conv1_on, link.line};

  // Every pin crosses two flops before any logic sees it
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        // Line idles high; a low reset value would fake a rising edge
        sync1_reg[gi] <= (gi == 0);
        sync2_reg[gi] <= (gi == 0);
      end else begin
        sync1_reg[gi] <= pins[gi];
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  end

  assign line_s = sync2_reg[0];
  assign active = sync2_reg[1] | sync2_reg[2];
  assign sel_s = sync2_reg[3];
  assign fall = line_d_reg & ~line_s;
  assign rise = ~line_d_reg & line_s;

  opsvi_dst_t state_reg, state_next;
  logic [CNT_W-1:0] lowrun_reg, lowrun_next;
  logic [CNT_W-1:0] cnt_lo_reg, cnt_lo_next;
  logic [CNT_W-1:0] cnt_hi_reg, cnt_hi_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;
  logic [4:0] bitn_reg, bitn_next;
  logic err_reg, err_next;
  logic [VAL_W-1:0] c1lo_reg, c1lo_next;
  logic [VAL_W-1:0] c1hi_reg, c1hi_next;
  logic [VAL_W-1:0] c2_reg, c2_next;
  logic [VAL_W-1:0] lvl1_reg, lvl1_next;
  logic pwm_reg, pwm_next;
  logic pull_reg, pull_next;
  logic [CNT_W-1:0] hi_inc;
  logic bit_one;
  logic bit_zero;
  logic [FRAME_BITS-1:0] frame;
  logic frame_ok;
  logic [1:0] sel;
  logic timed_out;

  always_comb begin
    state_next = state_reg;
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    shift_next = shift_reg;
    bitn_next = bitn_reg;
    err_next = err_reg;
    c1lo_next = c1lo_reg;
    c1hi_next = c1hi_reg;
    c2_next = c2_reg;
    pull_next = pull_reg;
    hi_inc = (cnt_hi_reg == '1) ? cnt_hi_reg : cnt_hi_reg + 1'b1;
    lowrun_next = line_s ? '0 : ((lowrun_reg == '1) ? lowrun_reg : lowrun_reg + 1'b1);
    timed_out = lowrun_reg >= TO_LIM;
    // High at once forces fixed frequency; only a long low releases it
    pwm_next = line_s ? 1'b1 : (timed_out ? 1'b0 : pwm_reg);
    // Ratio of at least two decides the bit; anything between is an error
    bit_one = {1'b0, cnt_hi_reg} >= {cnt_lo_reg, 1'b0};
    bit_zero = {1'b0, cnt_lo_reg} >= {cnt_hi_reg, 1'b0};
    frame = {shift_reg[FRAME_BITS-2:0], bit_one};
    sel = {frame[SEL_HI_POS], frame[SEL_LO_POS]};
    frame_ok = 1'b0;
    case (state_reg)
      ST_OFF: begin
        cnt_hi_next = '0;
        if (active) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        cnt_hi_next = hi_inc;
        if (cnt_hi_reg == WAKE_END) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fall) begin
          state_next = ST_LOW;
          bitn_next = '0;
          err_next = 1'b0;
        end
      end
      ST_LOW: begin
        if (timed_out) begin
          state_next = ST_IDLE;
        end else if (rise) begin
          state_next = ST_HIGH;
          cnt_lo_next = lowrun_reg;
          cnt_hi_next = '0;
        end
      end
      ST_HIGH: begin
        cnt_hi_next = hi_inc;
        if (fall) begin
          shift_next = frame;
          err_next = err_reg | ~(bit_one | bit_zero);
          bitn_next = bitn_reg + 5'h01;
          if (bitn_next == 5'(FRAME_BITS)) begin
            // All bits clean and address equal, else not for us
            frame_ok = ~err_next && (frame[FRAME_BITS-1:BYTE_BITS] == DEV_ADDR);
            if (frame_ok) begin
              case (sel)
                SEL_C1_LOW: c1lo_next = frame[VAL_W-1:0];
                SEL_C1_HIGH: begin
                  if (DIGITAL_SEL) begin
                    c1hi_next = frame[VAL_W-1:0];
                  end
                end
                SEL_C2: c2_next = frame[VAL_W-1:0];
                default: begin
                end
              endcase
            end
            cnt_hi_next = '0;
            state_next = (frame_ok && frame[RFA_POS]) ? ST_ACKW : ST_IDLE;
          end else if (bitn_next == 5'(BYTE_BITS)) begin
            state_next = ST_GAP_LO;
          end else begin
            state_next = ST_LOW;
          end
        end
      end
      ST_GAP_LO: begin
        if (timed_out) begin
          state_next = ST_IDLE;
        end else if (rise) begin
          state_next = ST_GAP_HI;
        end
      end
      ST_GAP_HI: begin
        if (fall) begin
          state_next = ST_LOW;
        end
      end
      ST_ACKW: begin
        cnt_hi_next = hi_inc;
        if (cnt_hi_reg == DLY_END) begin
          state_next = ST_ACK;
          pull_next = 1'b1;
          cnt_hi_next = '0;
        end
      end
      ST_ACK: begin
        cnt_hi_next = hi_inc;
        if (cnt_hi_reg == ACK_END) begin
          state_next = ST_IDLE;
          pull_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_OFF;
        pull_next = 1'b0;
      end
    endcase
    if (!active) begin
      state_next = ST_OFF;
      pull_next = 1'b0;
    end
    lvl1_next = (DIGITAL_SEL && sel_s) ? c1hi_next : c1lo_next;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_OFF;
      line_d_reg <= 1'b1;
      lowrun_reg <= '0;
      cnt_lo_reg <= '0;
      cnt_hi_reg <= '0;
      shift_reg <= '0;
      bitn_reg <= '0;
      err_reg <= 1'b0;
      c1lo_reg <= C1_LOW_RST;
      c1hi_reg <= C1_HIGH_RST;
      c2_reg <= C2_RST;
      lvl1_reg <= C1_LOW_RST;
      pwm_reg <= 1'b0;
      pull_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      line_d_reg <= line_s;
      lowrun_reg <= lowrun_next;
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      shift_reg <= shift_next;
      bitn_reg <= bitn_next;
      err_reg <= err_next;
      c1lo_reg <= c1lo_next;
      c1hi_reg <= c1hi_next;
      c2_reg <= c2_next;
      lvl1_reg <= lvl1_next;
      pwm_reg <= pwm_next;
      pull_reg <= pull_next;
    end
  end

  // Open drain: value is always low, only the enable moves
  assign link.dev_o = 1'b0;
  assign link.dev_oe_n = ~pull_reg;
  assign conv1_level = lvl1_reg;
  assign conv2_level = c2_reg;
  assign forced_pwm = pwm_reg;
  assign iface_ready = ~(state_reg == ST_OFF || state_reg == ST_WAKE);
endmodule

// ===== opsvi_host.sv
// Controller end: AHB-Lite register slave that sends frames on the line
`timescale 1ns/1ps
module opsvi_host
  import opsvi_pkg::*;
#(
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int TMR_W = 16,
  parameter int START_CYCLES = START_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  opsvi_if.host link, // Shared line
  output logic conv1_on, // Converter 1 enable
  output logic conv2_on // Converter 2 enable
);
  typedef enum logic [9:0] {
    H_OFF = 10'h001,
    H_WAKE = 10'h002,
    H_IDLE = 10'h004,
    H_START = 10'h008,
    H_LOW = 10'h010,
    H_HIGH = 10'h020,
    H_EOS = 10'h040,
    H_ACKD = 10'h080,
    H_ACKR = 10'h100,
    H_ACKE = 10'h200
  } opsvi_hst_t;

  if (TMR_W < 10 || START_CYCLES < 1 || START_CYCLES > 2 ** TMR_W) begin : g_bad
    $error("opsvi_host: start count does not fit the timer");
  end

  function automatic logic drives_low(input opsvi_hst_t s);
    drives_low = (s == H_LOW) || (s == H_EOS) || (s == H_ACKD);
  endfunction

  logic sync1_reg;
  logic sync2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= link.line;
      sync2_reg <= sync1_reg;
    end
  end

  opsvi_hst_t state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;
  logic [4:0] bitn_reg, bitn_next;
  logic rfa_reg, rfa_next;
  logic ack_reg, ack_next;
  logic [1:0] en_reg, en_next;
  logic wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic drv_low_reg, drv_low_next;
  logic take;
  logic cmd_go;
  logic [TMR_W-1:0] lim;

  assign take = hsel & htrans[1] & hready;
  assign cmd_go = wr_reg && (addr_reg == CMD_OFS) && (state_reg == H_IDLE);

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg + 1'b1;
    shift_next = shift_reg;
    bitn_next = bitn_reg;
    rfa_next = rfa_reg;
    ack_next = ack_reg;
    en_next = en_reg;
    wr_next = take & hwrite;
    addr_next = take ? haddr[7:0] : addr_reg;
    rdata_next = rdata_reg;
    lim = '0;
    if (wr_reg && addr_reg == EN_OFS) begin
      en_next = {hwdata[EN_C2], hwdata[EN_C1]};
    end
    if (take && !hwrite) begin
      case (haddr[7:0])
        STAT_OFS: rdata_next = {29'h0, state_reg != H_OFF && state_reg != H_WAKE,
                                ack_reg, state_reg != H_IDLE};
        EN_OFS: rdata_next = {30'h0, en_reg};
        default: rdata_next = 32'h0;
      endcase
    end
    case (state_reg)
      H_OFF: begin
        tmr_next = '0;
        if (en_reg != 2'h0) begin
          state_next = H_WAKE;
        end
      end
      H_WAKE: begin
        if (tmr_reg == TMR_W'(START_CYCLES - 1)) begin
          state_next = H_IDLE;
        end
      end
      H_IDLE: begin
        tmr_next = '0;
        if (cmd_go) begin
          // Push-pull drivers must not ask for the reply
          rfa_next = hwdata[RFA_POS] & OPEN_DRAIN;
          shift_next = {DEV_ADDR, rfa_next, hwdata[SEL_HI_POS:0]};
          bitn_next = '0;
          ack_next = 1'b0;
          state_next = H_START;
        end
      end
      H_START: begin
        if (tmr_reg == TMR_W'(START_HOLD_CYC - 1)) begin
          state_next = H_LOW;
          tmr_next = '0;
        end
      end
      H_LOW: begin
        lim = shift_reg[FRAME_BITS-1] ? TMR_W'(BIT_SHORT_CYC - 1) : TMR_W'(BIT_LONG_CYC - 1);
        if (tmr_reg == lim) begin
          state_next = H_HIGH;
          tmr_next = '0;
        end
      end
      H_HIGH: begin
        lim = shift_reg[FRAME_BITS-1] ? TMR_W'(BIT_LONG_CYC - 1) : TMR_W'(BIT_SHORT_CYC - 1);
        if (tmr_reg == lim) begin
          shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
          bitn_next = bitn_reg + 5'h01;
          tmr_next = '0;
          if (bitn_next == 5'(BYTE_BITS) || bitn_next == 5'(FRAME_BITS)) begin
            state_next = H_EOS;
          end else begin
            state_next = H_LOW;
          end
        end
      end
      H_EOS: begin
        if (tmr_reg == TMR_W'(EOS_CYC - 1)) begin
          tmr_next = '0;
          if (bitn_reg != 5'(FRAME_BITS)) begin
            state_next = H_START;
          end else begin
            state_next = rfa_reg ? H_ACKD : H_IDLE;
          end
        end
      end
      H_ACKD: begin
        // Line stays low past the device's reply delay
        if (tmr_reg == TMR_W'(HOST_ACK_WAIT_CYC - 1)) begin
          state_next = H_ACKR;
          tmr_next = '0;
        end
      end
      H_ACKR: begin
        if (tmr_reg == TMR_W'(ACK_SAMPLE_CYC - 1)) begin
          ack_next = ~sync2_reg;
          state_next = H_ACKE;
        end
      end
      H_ACKE: begin
        // No bound: the device ends its reply by itself
        if (sync2_reg) begin
          state_next = H_IDLE;
        end
      end
      default: state_next = H_OFF;
    endcase
    if (en_reg == 2'h0) begin
      state_next = H_OFF;
    end
    drv_low_next = drives_low(state_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= H_OFF;
      tmr_reg <= '0;
      shift_reg <= '0;
      bitn_reg <= '0;
      rfa_reg <= 1'b0;
      ack_reg <= 1'b0;
      en_reg <= 2'h0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0;
      drv_low_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      shift_reg <= shift_next;
      bitn_reg <= bitn_next;
      rfa_reg <= rfa_next;
      ack_reg <= ack_next;
      en_reg <= en_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      drv_low_reg <= drv_low_next;
    end
  end

  // Open drain releases for a one; push-pull drives it
  assign link.host_o = OPEN_DRAIN ? 1'b0 : ~drv_low_reg;
  assign link.host_oe_n = OPEN_DRAIN ? ~drv_low_reg : 1'b0;
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conv1_on = en_reg[EN_C1];
  assign conv2_on = en_reg[EN_C2];
endmodule

// ===== opsvi_assertions.sv
// Wire-level checks on the shared line between controller and device
`timescale 1ns/1ps
module opsvi_assertions
  import opsvi_pkg::*;
#(
  parameter int ACK_CYCLES = ACK_MAX_CYC,
  parameter int DELAY_CYCLES = RESP_DELAY_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic host_o, // Controller pin value
  input wire logic host_oe_n, // Controller enable, low drives
  input wire logic dev_o, // Device pin value
  input wire logic dev_oe_n, // Device enable, low pulls
  input wire logic line // Resolved line
);
  logic [15:0] low_cnt_reg, hi_cnt_reg, ack_cnt_reg;
  logic [15:0] low_cnt_next, hi_cnt_next, ack_cnt_next;
  // Saturating run lengths, so a stuck line never wraps to a small count
  always_comb begin
    low_cnt_next = line ? 16'h0000 : low_cnt_reg + 16'(low_cnt_reg != 16'hffff);
    hi_cnt_next = !line ? 16'h0000 : hi_cnt_reg + 16'(hi_cnt_reg != 16'hffff);
    ack_cnt_next = dev_oe_n ? 16'h0000 : ack_cnt_reg + 16'(ack_cnt_reg != 16'hffff);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= 16'h0000;
      hi_cnt_reg <= 16'h0000;
      ack_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= low_cnt_next;
      hi_cnt_reg <= hi_cnt_next;
      ack_cnt_reg <= ack_cnt_next;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence ack_begin;
    $fell(dev_oe_n);
  endsequence
  sequence ack_held;
    !dev_oe_n [*8];
  endsequence
  property ack_hold_p;
    ack_begin |=> ack_held;
  endproperty
  ack_low_only_a: assert property (!dev_oe_n |-> !dev_o)
    else $error("device drives the line high");
  ack_pulls_a: assert property (!dev_oe_n |-> !line)
    else $error("line not low during acknowledge");
  pullup_idle_a: assert property (host_oe_n && dev_oe_n |-> line)
    else $error("released line not high");
  no_fight_a: assert property (!dev_oe_n |-> host_oe_n || !host_o)
    else $error("controller drives high against acknowledge");
  ack_delay_a: assert property (ack_begin |-> low_cnt_reg >= 16'(DELAY_CYCLES))
    else $error("acknowledge before response delay");
  ack_bound_a: assert property (ack_cnt_reg <= 16'(ACK_CYCLES))
    else $error("acknowledge held too long");
  ack_hold_a: assert property (ack_hold_p)
    else $error("acknowledge pulse too short");
  bit_high_a: assert property ($fell(line) |-> hi_cnt_reg >= 16'(BIT_SHORT_CYC - 1))
    else $error("high phase shorter than a short bit phase");
endmodule

// ===== opsvi_test.sv
// Self-checking bench: AHB-Lite controller driving the device over the shared line
`timescale 1ns/1ps
module opsvi_test;
  import opsvi_pkg::*;
  localparam int DEV_START = 50;
  localparam int DEV_TO = 2000;
  localparam int DEV_ACK = 500;
  localparam int DEV_DLY = 100;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic sel_pin = 1'b0;
  logic drv_oe_n = 1'b1;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, c1_on, c2_on, forced_pwm, iface_ready;
  logic b_c1_on = 1'b0;
  logic b_c2_on = 1'b1;
  logic b_sel = 1'b0;
  logic pwm_b, iface_b;
  logic [4:0] conv1_level, conv2_level, lvl1_b, lvl2_b;
  logic [7:0] cmd_tab [4] = '{8'hb5, 8'h0a, 8'h5f, 8'he3};
  logic [4:0] c1_tab [4] = '{5'h15, 5'h15, 5'h0a, 5'h15};
  logic [4:0] c2_tab [4] = '{5'h00, 5'h00, 5'h1f, 5'h1f};
  logic pin_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int mismatches = 0;
  int cmp_count = 0;
  always #10 hclk = ~hclk;
  opsvi_if opsvi_if_inst();
  opsvi_if opsvi_if_inst2();
  // Second line: bench plays an open-drain controller that may break the frame rules
  assign opsvi_if_inst2.host_o = 1'b0;
  assign opsvi_if_inst2.host_oe_n = drv_oe_n;
  opsvi_host #(.START_CYCLES(DEV_START)) opsvi_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(opsvi_if_inst.host), .conv1_on(c1_on),
    .conv2_on(c2_on));
  opsvi_dev #(.START_CYCLES(DEV_START), .TIMEOUT_CYCLES(DEV_TO), .ACK_CYCLES(DEV_ACK), .DELAY_CYCLES(DEV_DLY))
    opsvi_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(opsvi_if_inst.dev), .conv1_on(c1_on),
    .conv2_on(c2_on), .conv1_level_selector_pin(sel_pin), .conv1_level(conv1_level),
    .conv2_level(conv2_level), .forced_pwm(forced_pwm), .iface_ready(iface_ready));
  // Second device runs on converter 2 enable alone
  opsvi_dev #(.DIGITAL_SEL(1'b0), .START_CYCLES(DEV_START), .TIMEOUT_CYCLES(DEV_TO), .ACK_CYCLES(DEV_ACK),
    .DELAY_CYCLES(DEV_DLY)) opsvi_dev_inst2 (.hclk(hclk), .hresetn(hresetn), .link(opsvi_if_inst2.dev),
    .conv1_on(b_c1_on), .conv2_on(b_c2_on), .conv1_level_selector_pin(b_sel), .conv1_level(lvl1_b),
    .conv2_level(lvl2_b), .forced_pwm(pwm_b), .iface_ready(iface_b));
  opsvi_assertions #(.ACK_CYCLES(DEV_ACK), .DELAY_CYCLES(DEV_DLY)) opsvi_assertions_inst (.hclk(hclk),
    .hresetn(hresetn), .host_o(opsvi_if_inst.host_o), .host_oe_n(opsvi_if_inst.host_oe_n),
    .dev_o(opsvi_if_inst.dev_o), .dev_oe_n(opsvi_if_inst.dev_oe_n), .line(opsvi_if_inst.line));
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic read_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    check(rd & mask, exp);
  endtask
  // Polls with gaps so a frame of several thousand cycles costs few bus cycles
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      repeat (20) @(posedge hclk);
      ahb(1'b0, STAT_OFS, 32'h00000000);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 2000);
  endtask
  task automatic send_byte(input logic [7:0] b);
    drv_oe_n <= 1'b1;
    repeat (START_HOLD_CYC) @(posedge hclk);
    for (int i = 7; i >= 0; i--) begin
      drv_oe_n <= 1'b0;
      repeat (b[i] ? BIT_SHORT_CYC : BIT_LONG_CYC) @(posedge hclk);
      drv_oe_n <= 1'b1;
      repeat (b[i] ? BIT_LONG_CYC : BIT_SHORT_CYC) @(posedge hclk);
    end
    drv_oe_n <= 1'b0;
    repeat (EOS_CYC) @(posedge hclk);
  endtask
  task automatic send_frame(input logic [7:0] a, input logic [7:0] d, input logic ack);
    send_byte(a);
    send_byte(d);
    repeat (HOST_ACK_WAIT_CYC) @(posedge hclk);
    drv_oe_n <= 1'b1;
    repeat (ACK_SAMPLE_CYC) @(posedge hclk);
    check(32'(!opsvi_if_inst2.line), 32'(ack));
    repeat (600) @(posedge hclk);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_check(STAT_OFS, 32'h00000007, 32'h00000001);
    check(32'(hresp), 32'h00000000);
    read_check(8'h40, 32'hffffffff, 32'h00000000);
    check(32'(iface_ready), 32'h00000000);
    ahb(1'b1, EN_OFS, 32'h00000003);
    read_check(EN_OFS, 32'h00000003, 32'h00000003);
    check(32'({c2_on, c1_on}), 32'h00000003);
    repeat (DEV_START + 20) @(posedge hclk);
    check(32'(iface_ready), 32'h00000001);
    read_check(STAT_OFS, 32'h00000005, 32'h00000004);
    for (int i = 0; i < 4; i++) begin
      sel_pin <= pin_tab[i];
      ahb(1'b1, CMD_OFS, 32'(cmd_tab[i]));
      wait_idle();
      read_check(STAT_OFS, 32'h00000002, 32'({cmd_tab[i][7], 1'b0}));
      check(32'(conv1_level), 32'(c1_tab[i]));
      check(32'(conv2_level), 32'(c2_tab[i]));
      check(32'(forced_pwm), 32'h00000001);
    end
    ahb(1'b1, EN_OFS, 32'h00000000);
    repeat (8) @(posedge hclk);
    check(32'(iface_ready), 32'h00000000);
    check(32'(iface_b), 32'h00000001);
    send_frame(DEV_ADDR, 8'hc1, 1'b1);
    check(32'(lvl2_b), 32'h00000001);
    b_sel <= 1'b1;
    send_frame(DEV_ADDR, 8'h27, 1'b0);
    check(32'(lvl1_b), 32'h00000000);
    send_frame(8'h4f, 8'hc2, 1'b0);
    check(32'(lvl2_b), 32'h00000001);
    drv_oe_n <= 1'b0;
    repeat (DEV_TO / 2) @(posedge hclk);
    check(32'(pwm_b), 32'h00000001);
    repeat (DEV_TO / 2 + 100) @(posedge hclk);
    check(32'(pwm_b), 32'h00000000);
    drv_oe_n <= 1'b1;
    repeat (5) @(posedge hclk);
    check(32'(pwm_b), 32'h00000001);
    b_c2_on <= 1'b0;
    repeat (8) @(posedge hclk);
    check(32'(iface_b), 32'h00000000);
    complete_run();
  end
  // About 56000 cycles expected; the margin covers slow acknowledge waits
  initial begin
    repeat (90000) @(posedge hclk);
    mismatches++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end
endmodule
